// ===== ppr_pa_ctrl.sv
`timescale 1ns/1ps
// How it works
// - eight slots each hold a 7-bit level
// - 3-bit index names final or direct slot
// - ramp enable steps power through slot levels
// - step length counts eighths of bit period
// - max power forces top level, stops ramping
// - smoothing enable drives internal data to FIR
// - FIR enable puts smoothing filter in path
// - FIR config code 10b selects switching
// - two bits pick Bessel bandwidth
// - degeneration bit enables pre-distortion mode
// - trim picks code threshold and clamp
// - ASK calibrator started during transmit
module ppr_pa_ctrl #(
  parameter int NUM_SLOTS = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Modem timing
  input wire logic tx_active,
  input wire logic eighth_tick,
  // Amplifier side
  output logic [6:0] pa_level,
  output ppr_pkg::ppr_pa_s pa_cfg,
  output logic tx_data_smooth,
  input wire logic tx_data,
  output logic ask_cal_enable,
  output logic ask_cal_start,
  output logic ramp_done
);
  import ppr_pkg::*;

  // Slot count is fixed by the 3-bit index and the register map
  if (NUM_SLOTS != 8) begin : g_bad_slots
    $error("slot count must be eight");
  end

  logic [7:0] cfg_r [NREG];
  logic [31:0] prdata_r;
  logic err_r;
  logic tx_d_r;
  logic [6:0] level_r;
  logic [6:0] level_nxt;
  ppr_pa_s cfg_out_r;
  logic smooth_r;
  logic ask_en_r;
  logic ask_start_r;
  logic [4:0] dec_w;
  logic [4:0] dec_r;
  logic [7:0] rd_byte;
  logic [7:0] ramp_reg;
  logic [7:0] fir_reg;
  logic [7:0] trim_reg;
  logic ramp_run;
  logic seq_start;
  logic [2:0] seq_idx;
  logic seq_done;

  // Address decode: hit flag and array position
  function automatic logic [4:0] reg_decode(input logic [11:0] a);
    logic [9:0] idx;
    idx = a[11:2];
    reg_decode = 5'h00;
    if (idx >= IDX_SLOT8 && idx <= IDX_TRIM_FILT) begin
      reg_decode = {1'b1, 4'(idx - IDX_SLOT8)};
    end
  endfunction

  // Level held in slot n (0 is the first slot)
  function automatic logic [6:0] slot_level(input logic [2:0] n);
    slot_level = 7'h00;
    for (int i = 0; i < NUM_SLOTS; i++) begin
      if (3'(i) == n) begin
        slot_level = cfg_r[7-i][6:0];
      end
    end
  endfunction

  assign dec_w = reg_decode(paddr);
  assign dec_r = reg_decode(paddr);
  assign ramp_reg = cfg_r[POS_RAMP];
  assign fir_reg = cfg_r[POS_FIR];
  assign trim_reg = cfg_r[POS_TRIM];

  // Zero-wait APB answer; data captured in the setup cycle
  assign pready = psel && penable;
  assign pslverr = psel && penable && err_r;
  assign prdata = prdata_r;

  // Register array; reserved bits keep their reset value
  genvar g;
  generate
    for (g = 0; g < NREG; g++) begin : g_regs
      always_ff @(posedge clk) begin
        if (reset) begin
          cfg_r[g] <= RST_VALS[g];
        end else if (psel && penable && pwrite && dec_w[4] && dec_w[3:0] == 4'(g)) begin
          cfg_r[g] <= (pwdata[7:0] & WR_MASK[g]) | (RST_VALS[g] & ~WR_MASK[g]);
        end
      end
    end
  endgenerate

  // Read mux
  always_comb begin
    rd_byte = 8'h00;
    if (dec_r[4]) begin
      rd_byte = cfg_r[dec_r[3:0]];
    end
  end

  // Read data and error captured during setup
  always_ff @(posedge clk) begin
    if (reset) begin
      prdata_r <= 32'h0000_0000;
      err_r <= 1'b0;
    end else if (psel && !penable) begin
      prdata_r <= {24'h00_0000, rd_byte};
      err_r <= ~dec_r[4];
    end
  end

  // Ramp runs only when enabled and max power is off
  assign ramp_run = ramp_reg[RC_RAMP] && !ramp_reg[RC_MAX] && tx_active;
  assign seq_start = tx_active && !tx_d_r;

  ppr_ramp_seq u_seq (
    .clk(clk),
    .reset(reset),
    .start(seq_start),
    .run(ramp_run),
    .eighth_tick(eighth_tick),
    .step_len(ramp_reg[RC_STEP_LO +: 2]),
    .final_idx(ramp_reg[RC_IDX_LO +: 3]),
    .slot_idx(seq_idx),
    .done(seq_done)
  );

  // Transmit edge tracking
  always_ff @(posedge clk) begin
    if (reset) begin
      tx_d_r <= 1'b0;
    end else begin
      tx_d_r <= tx_active;
    end
  end

  // Level selection: max power, direct slot, or ramp slot
  always_comb begin
    if (ramp_reg[RC_MAX]) begin
      level_nxt = PWR_MAX;
    end else if (!ramp_reg[RC_RAMP]) begin
      level_nxt = slot_level(ramp_reg[RC_IDX_LO +: 3]);
    end else begin
      level_nxt = slot_level(seq_idx);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      level_r <= 7'h00;
    end else begin
      level_r <= level_nxt;
    end
  end

  // Analog configuration outputs
  always_ff @(posedge clk) begin
    if (reset) begin
      cfg_out_r <= '0;
    end else begin
      cfg_out_r.max_power_override <= ramp_reg[RC_MAX];
      cfg_out_r.smoothing_data_enable <= ramp_reg[RC_SMOOTH];
      cfg_out_r.smoothing_filter_enable <= fir_reg[FC_EN];
      cfg_out_r.smoothing_filter_config <= fir_reg[FC_CFG_LO +: 2];
      cfg_out_r.fir_switching <= fir_reg[FC_CFG_LO +: 2] == SMOOTHING_FILTER_CONFIG_SWITCH;
      cfg_out_r.bessel_bandwidth_select <= trim_reg[TR_FC_LO +: 2];
      cfg_out_r.predistortion_enable <= trim_reg[TR_DEGEN];
      cfg_out_r.code_threshold <= ppr_threshold(trim_reg[TR_THR_LO +: 2]);
      cfg_out_r.clamp_select <= trim_reg[TR_CLAMP_LO +: 2];
    end
  end

  // Internal smoothed data feeding the FIR, gated by the enable
  always_ff @(posedge clk) begin
    if (reset) begin
      smooth_r <= 1'b0;
    end else begin
      smooth_r <= ramp_reg[RC_SMOOTH] && tx_active && tx_data;
    end
  end

  // ASK calibrator enable and start pulse
  always_ff @(posedge clk) begin
    if (reset) begin
      ask_en_r <= 1'b0;
      ask_start_r <= 1'b0;
    end else begin
      ask_en_r <= trim_reg[TR_ASK] && tx_active;
      ask_start_r <= trim_reg[TR_ASK] && seq_start;
    end
  end

  assign pa_level = level_r;
  assign pa_cfg = cfg_out_r;
  assign tx_data_smooth = smooth_r;
  assign ask_cal_enable = ask_en_r;
  assign ask_cal_start = ask_start_r;
  assign ramp_done = seq_done;

  // Transmit start and calibrator pulse shapes
  sequence s_tx_rise;
    tx_active && !tx_d_r;
  endsequence

  sequence s_ask_pulse;
    ##1 ask_cal_start ##1 !ask_cal_start;
  endsequence

  chk_max_level: assert property (@(posedge clk) disable iff (reset)
    !reset && ramp_reg[RC_MAX] ##1 ramp_reg[RC_MAX] |-> pa_level == PWR_MAX && pa_cfg.max_power_override)
    else $error("max power not applied");

  chk_max_no_ramp: assert property (@(posedge clk) disable iff (reset)
    ramp_reg[RC_MAX] |-> !ramp_run)
    else $error("ramp active under max power");

  chk_direct_slot: assert property (@(posedge clk) disable iff (reset)
    !ramp_reg[RC_MAX] && !ramp_reg[RC_RAMP] && $stable(ramp_reg) && $stable(cfg_r[POS_SLOT1])
      && !(psel && penable && pwrite)
      |=> pa_level == slot_level($past(ramp_reg[RC_IDX_LO +: 3], 1)))
    else $error("direct level differs from indexed slot");

  chk_ramp_first: assert property (@(posedge clk) disable iff (reset)
    s_tx_rise ##0 ramp_run |=> seq_idx == 3'h0)
    else $error("ramp did not start at lowest slot");

  chk_ramp_climb: assert property (@(posedge clk) disable iff (reset)
    ramp_run && $past(ramp_run, 1) && seq_idx != $past(seq_idx, 1)
      |-> seq_idx == $past(seq_idx, 1) + 3'h1)
    else $error("ramp skipped a slot");

  chk_ramp_bound: assert property (@(posedge clk) disable iff (reset)
    ramp_run && $stable(ramp_reg) && seq_done |-> seq_idx == ramp_reg[RC_IDX_LO +: 3])
    else $error("ramp ended off the final slot");

  chk_ask_start: assert property (@(posedge clk) disable iff (reset)
    s_tx_rise ##0 trim_reg[TR_ASK] |-> s_ask_pulse)
    else $error("calibrator start pulse missing");

  chk_fir_switch: assert property (@(posedge clk) disable iff (reset)
    ##1 pa_cfg.fir_switching == ($past(fir_reg[FC_CFG_LO +: 2], 1) == SMOOTHING_FILTER_CONFIG_SWITCH))
    else $error("switching flag wrong");

  chk_trim_thr: assert property (@(posedge clk) disable iff (reset)
    !reset && $stable(trim_reg) ##1 $stable(trim_reg) |->
      pa_cfg.code_threshold == ppr_threshold(trim_reg[TR_THR_LO +: 2])
      && pa_cfg.clamp_select == trim_reg[TR_CLAMP_LO +: 2])
    else $error("trim outputs wrong");

  chk_bw_flags: assert property (@(posedge clk) disable iff (reset)
    !reset && $stable(trim_reg) && $stable(fir_reg) ##1 $stable(trim_reg) && $stable(fir_reg) |->
      pa_cfg.bessel_bandwidth_select == trim_reg[TR_FC_LO +: 2]
      && pa_cfg.predistortion_enable == trim_reg[TR_DEGEN]
      && pa_cfg.smoothing_filter_enable == fir_reg[FC_EN])
    else $error("bandwidth or flag outputs wrong");

  chk_smooth_gate: assert property (@(posedge clk) disable iff (reset)
    !ramp_reg[RC_SMOOTH] |=> !tx_data_smooth)
    else $error("smoothing data without enable");

  // Smoothed data repeats the raw data while enabled during transmit
  chk_smooth_follow: assert property (@(posedge clk) disable iff (reset)
    ramp_reg[RC_SMOOTH] && tx_active |=> tx_data_smooth == $past(tx_data, 1))
    else $error("smoothed data does not follow raw data");

  // Calibrator enable follows transmit one cycle late
  chk_ask_level: assert property (@(posedge clk) disable iff (reset)
    !reset |=> ask_cal_enable == $past(trim_reg[TR_ASK] && tx_active, 1))
    else $error("calibrator enable wrong");

  // No calibrator activity while its bit is clear
  chk_ask_quiet: assert property (@(posedge clk) disable iff (reset)
    !trim_reg[TR_ASK] |=> !ask_cal_start && !ask_cal_enable)
    else $error("calibrator active without its bit");

  // Sequencer parks on the lowest slot outside transmit
  chk_ramp_idle: assert property (@(posedge clk) disable iff (reset)
    !tx_active |=> seq_idx == 3'h0 && !ramp_done)
    else $error("ramp not parked at lowest slot");

  // Ramp level is the slot that the sequencer points at
  chk_level_ramp: assert property (@(posedge clk) disable iff (reset)
    !reset && ramp_run && !(psel && penable && pwrite)
      |=> pa_level == slot_level($past(seq_idx, 1)))
    else $error("ramp level differs from sequencer slot");
endmodule

// ===== ppr_pkg.sv
package ppr_pkg;
  // Register count and printed indices; byte address is four times the index
  localparam int NREG = 11;
  localparam logic [9:0] IDX_SLOT8 = 10'h05A;
  localparam logic [9:0] IDX_SLOT7 = 10'h05B;
  localparam logic [9:0] IDX_SLOT6 = 10'h05C;
  localparam logic [9:0] IDX_SLOT5 = 10'h05D;
  localparam logic [9:0] IDX_SLOT4 = 10'h05E;
  localparam logic [9:0] IDX_SLOT3 = 10'h05F;
  localparam logic [9:0] IDX_SLOT2 = 10'h060;
  localparam logic [9:0] IDX_SLOT1 = 10'h061;
  localparam logic [9:0] IDX_RAMP_CTRL = 10'h062;
  localparam logic [9:0] IDX_SMOOTHING_FILTER_CONFIG = 10'h063;
  localparam logic [9:0] IDX_TRIM_FILT = 10'h064;

  // Array positions of the non-slot registers and of slot 1
  localparam logic [3:0] POS_RAMP = 4'h8;
  localparam logic [3:0] POS_FIR = 4'h9;
  localparam logic [3:0] POS_TRIM = 4'hA;
  localparam logic [3:0] POS_SLOT1 = 4'h7;

  // Reset values, position 10 down to 0
  localparam logic [NREG-1:0][7:0] RST_VALS = {
    8'h8A, 8'h03, 8'h47, 8'h00, 8'h60, 8'h48,
    8'h30, 8'h24, 8'h18, 8'h0C, 8'h01};
  // Writable bits; others are reserved and read their reset value
  localparam logic [NREG-1:0][7:0] WR_MASK = {
    8'hFF, 8'h0E, 8'hFF, 8'h7F, 8'h7F, 8'h7F,
    8'h7F, 8'h7F, 8'h7F, 8'h7F, 8'h7F};

  // Field positions in the ramp control register
  localparam int RC_SMOOTH = 7;
  localparam int RC_MAX = 6;
  localparam int RC_RAMP = 5;
  localparam int RC_STEP_LO = 3;
  localparam int RC_IDX_LO = 0;
  // Field positions in the FIR register
  localparam int FC_CFG_LO = 2;
  localparam int FC_EN = 1;
  // Field positions in the trim register
  localparam int TR_THR_LO = 6;
  localparam int TR_CLAMP_LO = 4;
  localparam int TR_DEGEN = 3;
  localparam int TR_ASK = 2;
  localparam int TR_FC_LO = 0;

  // Encodings and levels
  localparam logic [1:0] SMOOTHING_FILTER_CONFIG_SWITCH = 2'h2;
  localparam logic [6:0] PWR_MAX = 7'h7F;
  localparam logic [1:0] BW_50K = 2'h2;
  localparam logic [1:0] BW_100K = 2'h3;
  localparam logic [8:0] THR_0 = 9'd418;
  localparam logic [8:0] THR_1 = 9'd439;
  localparam logic [8:0] THR_2 = 9'd465;
  localparam logic [8:0] THR_3 = 9'd485;

  // Amplifier configuration carried to the analog side
  typedef struct packed {
    logic max_power_override;
    logic smoothing_data_enable;
    logic smoothing_filter_enable;
    logic [1:0] smoothing_filter_config;
    logic fir_switching;
    logic [1:0] bessel_bandwidth_select;
    logic predistortion_enable;
    logic [8:0] code_threshold;
    logic [1:0] clamp_select;
  } ppr_pa_s;

  // Code threshold for the upper trim bits
  function automatic logic [8:0] ppr_threshold(input logic [1:0] sel);
    case (sel)
      2'h0: ppr_threshold = THR_0;
      2'h1: ppr_threshold = THR_1;
      2'h2: ppr_threshold = THR_2;
      default: ppr_threshold = THR_3;
    endcase
  endfunction
endpackage

// ===== ppr_ramp_seq.sv
`timescale 1ns/1ps
module ppr_ramp_seq (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Control
  input wire logic start,
  input wire logic run,
  input wire logic eighth_tick,
  input wire logic [1:0] step_len,
  input wire logic [2:0] final_idx,
  // Status
  output logic [2:0] slot_idx,
  output logic done
);
  import ppr_pkg::*;

  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_STEP = 3'b010,
    S_HOLD = 3'b100
  } ppr_seq_e;

  ppr_seq_e state_r;
  logic [1:0] cnt_r;
  logic [2:0] idx_r;
  logic last_tick;

  // Last eighth of the current step
  assign last_tick = eighth_tick && (cnt_r == step_len);
  assign slot_idx = idx_r;
  assign done = (state_r == S_HOLD);

  // Step through slots from the lowest up to the final one
  always_ff @(posedge clk) begin
    if (reset || !run) begin
      state_r <= S_IDLE;
      idx_r <= 3'h0;
    end else begin
      unique case (state_r)
        S_IDLE: begin
          if (start) begin
            idx_r <= 3'h0;
            state_r <= (final_idx == 3'h0) ? S_HOLD : S_STEP;
          end
        end
        S_STEP: begin
          if (last_tick) begin
            idx_r <= idx_r + 3'h1;
            if (idx_r + 3'h1 == final_idx) begin
              state_r <= S_HOLD;
            end
          end
        end
        S_HOLD: begin
          state_r <= S_HOLD;
        end
      endcase
    end
  end

  // Eighth-bit counter within a step
  always_ff @(posedge clk) begin
    if (reset || state_r != S_STEP) begin
      cnt_r <= 2'h0;
    end else if (eighth_tick) begin
      cnt_r <= last_tick ? 2'h0 : cnt_r + 2'h1;
    end
  end

  chk_step_on_tick: assert property (@(posedge clk) disable iff (reset)
    (state_r == S_STEP && run && idx_r != $past(idx_r, 1) && $past(run, 1))
      |-> $past(last_tick, 1) || $past(state_r == S_IDLE, 1))
    else $error("slot index moved without a full step");
endmodule

// ===== ppr_pa_ctrl_test.sv
`timescale 1ns/1ps
module ppr_pa_ctrl_test;
  import ppr_pkg::*;
  // Clock, reset and stimulus
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic tx_active = 1'b0;
  logic eighth_tick = 1'b0;
  logic tx_data = 1'b0;
  // Observed outputs
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [6:0] pa_level;
  ppr_pa_s pa_cfg;
  logic tx_data_smooth;
  logic ask_cal_enable;
  logic ask_cal_start;
  logic ramp_done;
  // Bookkeeping
  int miscompares = 0;
  int comparisons = 0;
  int cycles = 0;
  int pulses;
  logic [31:0] rd;
  logic err;
  // Reset values from the slot 8 word up to the trim word
  logic [7:0] rst_tab [11] = '{8'h01, 8'h0C, 8'h18, 8'h24, 8'h30, 8'h48, 8'h60, 8'h00, 8'h47, 8'h03, 8'h8A};
  logic [8:0] thr_tab [4] = '{9'd418, 9'd439, 9'd465, 9'd485};

  ppr_pa_ctrl DUT (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_active(tx_active), .eighth_tick(eighth_tick), .pa_level(pa_level), .pa_cfg(pa_cfg),
    .tx_data_smooth(tx_data_smooth), .tx_data(tx_data), .ask_cal_enable(ask_cal_enable),
    .ask_cal_start(ask_cal_start), .ramp_done(ramp_done));

  // 200 MHz clock
  initial begin
    forever #2.5 clk = ~clk;
  end

  // Hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      tally_and_finish;
    end
  end

  task automatic tally_and_finish;
    if (miscompares == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  // One APB transfer; entered just after a rising edge, leaves one idle cycle
  task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    check("access cycles", 32'h1, n);
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask

  task automatic rd_chk(input string name, input logic [9:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    check(name, {24'h0, exp}, rd);
    check("slverr", 32'h0, {31'h0, err});
  endtask

  task automatic tick(input int n);
    repeat (n) begin
      eighth_tick <= 1'b1;
      @(posedge clk);
      eighth_tick <= 1'b0;
      @(posedge clk);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 11; i++) rd_chk("reset value", 10'(10'h05A + i), rst_tab[i]);
    check("level after reset", 32'h7F, pa_level);
    // Unmapped words refuse and read zero
    apb(1'b0, 10'h059, 8'h00);
    check("unmapped err", 32'h1, {31'h0, err});
    check("unmapped data", 32'h0, rd);
    wr(10'h065, 8'hFF);
    apb(1'b0, 10'h065, 8'h00);
    check("unmapped err", 32'h1, {31'h0, err});
    check("unmapped data", 32'h0, rd);
    // Reserved bits keep their reset value
    wr(10'h05A, 8'hFF);
    rd_chk("slot reserved", 10'h05A, 8'h7F);
    // Distinct slot levels, then each index applied directly
    for (int n = 0; n < 8; n++) wr(10'(10'h061 - n), {1'b0, 3'(n), 4'h5});
    for (int n = 0; n < 8; n++) begin
      wr(10'h062, 8'(n));
      cyc(2);
      check("direct level", {3'(n), 4'h5}, pa_level);
    end
    // Every filter configuration code
    for (int c = 0; c < 4; c++) begin
      wr(10'h063, {4'h0, 2'(c), 2'b10});
      cyc(2);
      check("smoothing_filter_config", {1'b1, 2'(c), c == 2}, {pa_cfg.smoothing_filter_enable, pa_cfg.smoothing_filter_config,
        pa_cfg.fir_switching});
      rd_chk("fir read", 10'h063, {4'h0, 2'(c), 2'b11});
    end
    // Every trim, degeneration and bandwidth code
    for (int t = 0; t < 16; t++) begin
      wr(10'h064, {4'(t), 1'(t), 1'b0, 2'(t >> 2)});
      cyc(2);
      check("trim fields", {thr_tab[t >> 2], 2'(t), 1'(t), 2'(t >> 2)}, {pa_cfg.code_threshold,
        pa_cfg.clamp_select, pa_cfg.predistortion_enable, pa_cfg.bessel_bandwidth_select});
    end
    // Ramp with each step length, final index one above the step code
    for (int s = 0; s < 4; s++) begin
      wr(10'h062, 8'(32 + s * 8 + s + 1));
      cyc(2);
      check("idle level", 32'h05, pa_level);
      tx_active <= 1'b1;
      cyc(3);
      check("ramp start", 32'h05, pa_level);
      check("done early", 32'h0, {31'h0, ramp_done});
      for (int k = 1; k <= s + 1; k++) begin
        tick(s);
        cyc(1);
        check("step hold", {3'(k - 1), 4'h5}, pa_level);
        tick(1);
        cyc(1);
        check("step advance", {3'(k), 4'h5}, pa_level);
      end
      check("ramp done", 32'h1, {31'h0, ramp_done});
      tick(4);
      cyc(1);
      check("final hold", {3'(s + 1), 4'h5}, pa_level);
      tx_active <= 1'b0;
      cyc(3);
      check("abort level", 32'h05, pa_level);
    end
    // Maximum power overrides ramping
    wr(10'h062, 8'h6B);
    tx_active <= 1'b1;
    cyc(3);
    check("max level", 32'h7F, pa_level);
    check("max flag", 32'h1, {31'h0, pa_cfg.max_power_override});
    tick(8);
    cyc(1);
    check("max no ramp", 32'h7F, pa_level);
    tx_active <= 1'b0;
    wr(10'h062, 8'h03);
    cyc(2);
    check("max cleared", 32'h35, pa_level);
    // Smoothing data on and off
    for (int b = 0; b < 2; b++) begin
      wr(10'h062, 8'(b * 128));
      tx_active <= 1'b1;
      tx_data <= 1'b1;
      cyc(3);
      check("smooth data", b, {31'h0, tx_data_smooth});
      check("smooth flag", b, {31'h0, pa_cfg.smoothing_data_enable});
      tx_data <= 1'b0;
      cyc(3);
      check("smooth low", 32'h0, {31'h0, tx_data_smooth});
      tx_active <= 1'b0;
      cyc(1);
    end
    // Calibrator start on transmit
    for (int b = 0; b < 2; b++) begin
      wr(10'h064, 8'(b * 4));
      tx_active <= 1'b1;
      pulses = 0;
      repeat (8) begin
        @(posedge clk);
        if (ask_cal_start === 1'b1) pulses++;
      end
      check("ask pulses", b, pulses);
      check("ask enable", b, {31'h0, ask_cal_enable});
      tx_active <= 1'b0;
      cyc(3);
      check("ask off", 32'h0, {31'h0, ask_cal_enable});
    end
    tally_and_finish;
  end
endmodule
